// ---- common/hdlc_irq_pkg.sv ----
/*
  Constants, types and helpers for the HDLC channel 2/3 event status block.
  Assumes one 100 MHz clock and word-aligned Wishbone register indices.
*/
package hdlc_irq_pkg;
  localparam logic [7:0] IDX_ADDR_LOW1 = 8'h22;
  localparam logic [7:0] IDX_TX_CMD = 8'h24;
  localparam logic [7:0] IDX_TX_OFFSET = 8'h25;
  localparam logic [7:0] IDX_MASK4 = 8'h2a;
  localparam logic [7:0] IDX_MASK5 = 8'h2b;
  localparam logic [7:0] IDX_CONFIG = 8'h3d;
  localparam logic [7:0] IDX_RX_COUNT2 = 8'h50;
  localparam logic [7:0] IDX_RX_COUNT3 = 8'h51;
  localparam logic [7:0] IDX_FRAME_STAT2 = 8'h52;
  localparam logic [7:0] IDX_FRAME_STAT3 = 8'h53;
  localparam logic [7:0] IDX_STATUS4 = 8'h6a;
  localparam logic [7:0] IDX_STATUS5 = 8'h6b;
  localparam logic [7:0] IDX_SUMMARY = 8'h6e;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hff;
  localparam int B_SLIP_POS = 7;
  localparam int B_SLIP_NEG = 6;
  localparam int B_RME = 5;
  localparam int B_RFS = 4;
  localparam int B_RDO = 3;
  localparam int B_ALLS = 2;
  localparam int B_XDU = 1;
  localparam int B_RPF = 0;
  localparam int B_POOL_READY_CH2 = 7;
  localparam int B_POOL_READY_CH3 = 6;
  localparam int B_PLL = 6;
  localparam int B_VIS = 0;
  localparam int B_FRAME_OVF = 5;
  localparam logic [1:0] RFS_DELAY_BYTES = 2'h2;
  localparam logic [6:0] POOL_BYTES = 7'h20;
  localparam logic [5:0] TX_BLOCK_BYTES = 6'h20;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_HALT} tx_state_t;

  function automatic logic pending(input logic [7:0] status, input logic [7:0] mask);
    return |(status & ~mask);
  endfunction
endpackage

// ---- common/rx_event_if.sv ----
/*
  Receive-side signals of one HDLC channel between the top and its channel module.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface rx_event_if;
  logic rx_byte, begin_addr, begin_flag, transparent, fifo_full, frame_end, addr_low;
  logic [2:0] status_bits;
  logic [6:0] fifo_level;
  logic ev_rme, ev_rfs, ev_rdo, ev_rpf;
  logic [7:0] byte_count, frame_status;
  modport chan (input rx_byte, begin_addr, begin_flag, transparent, fifo_full, frame_end, addr_low,
    status_bits, fifo_level, output ev_rme, ev_rfs, ev_rdo, ev_rpf, byte_count, frame_status);
  modport top (output rx_byte, begin_addr, begin_flag, transparent, fifo_full, frame_end, addr_low,
    status_bits, fifo_level, input ev_rme, ev_rfs, ev_rdo, ev_rpf, byte_count, frame_status);
endinterface

// ---- design/rx_event_channel.sv ----
/*
  Receive event generation for one HDLC channel: message end, frame start, overflow, pool full.
  Assumes receive strobes come from logic on the same clock.
*/
`timescale 1ns/100ps
module rx_event_channel (
  // Clock, reset and enable.
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Receive side.
  rx_event_if.chan rx
);
  import hdlc_irq_pkg::*;
  logic begin_ev;
  logic fire;
  logic armed;
  logic in_frame;
  logic [1:0] left;
  logic [7:0] length;
  logic [6:0] prev_level;
  assign begin_ev = rx.transparent ? rx.begin_flag : rx.begin_addr;
  assign fire = armed && rx.rx_byte && left == 2'h1 && !begin_ev;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      armed <= 1'b0;
      left <= 2'h0;
    end else if (i_ce) begin
      if (begin_ev) begin
        armed <= 1'b1;
        left <= RFS_DELAY_BYTES;
      end else if (armed && rx.rx_byte) begin
        left <= left - 2'h1;
        armed <= (left != 2'h1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      in_frame <= 1'b0;
      length <= RST_ZERO;
      prev_level <= 7'h00;
      rx.ev_rme <= 1'b0;
      rx.ev_rfs <= 1'b0;
      rx.ev_rdo <= 1'b0;
      rx.ev_rpf <= 1'b0;
      rx.byte_count <= RST_ZERO;
      rx.frame_status <= RST_ZERO;
    end else if (i_ce) begin
      prev_level <= rx.fifo_level;
      rx.ev_rme <= rx.frame_end;
      rx.ev_rfs <= fire;
      rx.ev_rdo <= rx.rx_byte && rx.fifo_full;
      rx.ev_rpf <= in_frame && rx.fifo_level == POOL_BYTES && prev_level != POOL_BYTES;
      if (begin_ev) begin
        in_frame <= 1'b1;
        length <= 8'h00;
        rx.frame_status[B_FRAME_OVF] <= 1'b0;
      end else begin
        if (rx.frame_end) begin
          in_frame <= 1'b0;
          rx.byte_count <= {length[7], rx.fifo_level};
        end
        if (rx.rx_byte) begin
          length <= length + 8'h01;
        end
        if (rx.rx_byte && rx.fifo_full) begin
          rx.frame_status[B_FRAME_OVF] <= 1'b1;
        end
      end
      if (fire) begin
        rx.frame_status[3:1] <= rx.status_bits;
        rx.frame_status[0] <= rx.addr_low;
      end
    end
  end

  sequence seq_last_byte;
    i_ce && fire;
  endsequence
  chk_frame_start_delay: assert property (@(posedge i_clk) disable iff (!i_rstn)
    seq_last_byte |=> rx.ev_rfs && $past(left) == 2'h1)
    else $error("Frame start flag not raised on second byte.");
  chk_status_capture: assert property (@(posedge i_clk) disable iff (!i_rstn)
    seq_last_byte |=> rx.frame_status[3:1] == $past(rx.status_bits) && rx.frame_status[0] == $past(rx.addr_low))
    else $error("Frame status not captured at frame start.");
  chk_overflow_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && rx.rx_byte && rx.fifo_full && !begin_ev |=> rx.ev_rdo && rx.frame_status[B_FRAME_OVF])
    else $error("Overflow not flagged in event and frame status.");
  chk_message_count: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && rx.frame_end && !begin_ev |=> rx.ev_rme && rx.byte_count[6:0] == $past(rx.fifo_level))
    else $error("Message end or byte count wrong.");
  chk_pool_full: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && in_frame && rx.fifo_level == POOL_BYTES && prev_level != POOL_BYTES |=> rx.ev_rpf)
    else $error("Pool full not raised at 32 bytes.");
endmodule // rx_event_channel

// ---- design/hdlc_channel_interrupt_status.sv ----
/*
  Event status, masks and pending summary for HDLC channels 2 and 3, with a Wishbone slave.
  Assumes HDLC core strobes on the same clock; PLL lock arrives asynchronously.
*/
`timescale 1ns/100ps
module hdlc_channel_interrupt_status (
  // Clock, reset and enable.
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Slip events and outside status.
  input wire logic i_tx_slip_pos,
  input wire logic i_tx_slip_neg,
  input wire logic [3:0] i_other_pending,
  input wire logic i_pll_locked,
  // Receive side, index 0 is channel 2.
  input wire logic [1:0] i_rx_byte,
  input wire logic [1:0] i_begin_addr,
  input wire logic [1:0] i_begin_flag,
  input wire logic [1:0] i_transparent,
  input wire logic [1:0] i_rx_fifo_full,
  input wire logic [1:0] i_rx_frame_end,
  input wire logic [1:0] i_addr_low,
  input wire logic [1:0][2:0] i_status_bits,
  input wire logic [1:0][6:0] i_rx_fifo_level,
  // Transmit side, index 0 is channel 2.
  input wire logic [1:0] i_hdlc_mode,
  input wire logic [1:0] i_tx_byte_req,
  input wire logic [1:0] i_tx_fifo_empty,
  input wire logic [1:0] i_tx_last_bit,
  input wire logic [1:0][5:0] i_tx_space,
  output logic [1:0] o_tx_disable,
  output logic [1:0] o_tx_abort,
  // Configuration and interrupt.
  output logic [7:0] o_tx_clock_offset_cfg,
  output logic o_int
);
  import hdlc_irq_pkg::*;
  rx_event_if rxi[2] ();
  logic req;
  logic rd_take;
  logic wr_take;
  logic [7:0] idx;
  logic [7:0] rd_val;
  logic [7:0] mask4;
  logic [7:0] mask5;
  logic [7:0] status4;
  logic [7:0] status5;
  logic [7:0] ev4;
  logic [7:0] ev5;
  logic [7:0] rec4;
  logic [7:0] rec5;
  logic [7:0] summary;
  logic [7:0] next_summary;
  logic [7:0] addr_low1;
  logic masked_status_visible;
  logic slip_pos_ev;
  logic slip_neg_ev;
  logic pll_meta;
  logic pll_sync;
  logic rd4;
  logic rd5;
  logic [1:0] release_tx;
  logic [1:0] xme_cmd;
  logic [1:0] underrun;
  logic [1:0] xme_pend;
  logic [1:0] alls_ev;
  logic [1:0] xdu_ev;
  logic [1:0] xpr_ev;
  logic [1:0] space_ok;
  logic [1:0] space_was_ok;
  tx_state_t tx_state [2];

  assign idx = i_wb_adr[9:2];
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign rd_take = i_ce && req && !i_wb_we;
  assign wr_take = i_ce && req && i_wb_we && i_wb_sel[0];
  assign rd4 = rd_take && idx == IDX_STATUS4;
  assign rd5 = rd_take && idx == IDX_STATUS5;
  assign release_tx = {rd5, rd4};

  genvar g;
  for (g = 0; g < 2; g++) begin : g_chan
    assign rxi[g].rx_byte = i_rx_byte[g];
    assign rxi[g].begin_addr = i_begin_addr[g];
    assign rxi[g].begin_flag = i_begin_flag[g];
    assign rxi[g].transparent = i_transparent[g];
    assign rxi[g].fifo_full = i_rx_fifo_full[g];
    assign rxi[g].frame_end = i_rx_frame_end[g];
    assign rxi[g].addr_low = i_addr_low[g];
    assign rxi[g].status_bits = i_status_bits[g];
    assign rxi[g].fifo_level = i_rx_fifo_level[g];
    assign xme_cmd[g] = wr_take && idx == IDX_TX_CMD && i_wb_dat[g];
    assign underrun[g] = tx_state[g] == TX_SEND && i_tx_byte_req[g] && i_tx_fifo_empty[g] && !xme_pend[g];
    assign space_ok[g] = i_tx_space[g] >= TX_BLOCK_BYTES && tx_state[g] != TX_HALT;

    rx_event_channel u_rx (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .rx(rxi[g])
    );

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        tx_state[g] <= TX_IDLE;
        o_tx_disable[g] <= 1'b0;
        o_tx_abort[g] <= 1'b0;
        xdu_ev[g] <= 1'b0;
      end else if (i_ce) begin
        o_tx_abort[g] <= underrun[g];
        xdu_ev[g] <= underrun[g];
        case (tx_state[g])
          TX_IDLE: begin
            if (i_tx_byte_req[g] && !i_tx_fifo_empty[g]) begin
              tx_state[g] <= TX_SEND;
            end
          end
          TX_SEND: begin
            if (underrun[g]) begin
              tx_state[g] <= TX_HALT;
              o_tx_disable[g] <= 1'b1;
            end else if (i_tx_last_bit[g]) begin
              tx_state[g] <= TX_IDLE;
            end
          end
          TX_HALT: begin
            if (release_tx[g]) begin
              tx_state[g] <= TX_IDLE;
              o_tx_disable[g] <= 1'b0;
            end
          end
          default: begin
            tx_state[g] <= TX_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        xme_pend[g] <= 1'b0;
        alls_ev[g] <= 1'b0;
        xpr_ev[g] <= 1'b0;
        space_was_ok[g] <= 1'b0;
      end else if (i_ce) begin
        alls_ev[g] <= i_hdlc_mode[g] && i_tx_last_bit[g] && i_tx_fifo_empty[g];
        space_was_ok[g] <= space_ok[g];
        xpr_ev[g] <= space_ok[g] && !space_was_ok[g];
        if (xme_cmd[g]) begin
          xme_pend[g] <= 1'b1;
        end else if (i_tx_last_bit[g] || underrun[g] || tx_state[g] == TX_HALT) begin
          xme_pend[g] <= 1'b0;
        end
      end
    end

    sequence seq_underrun_hit;
      i_ce && underrun[g];
    endsequence
    chk_underrun_abort: assert property (@(posedge i_clk) disable iff (!i_rstn)
      seq_underrun_hit |=> o_tx_abort[g] && xdu_ev[g] && o_tx_disable[g])
      else $error("Underrun did not abort and disable the transmitter.");
    chk_disable_held: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_tx_disable[g] && !(i_ce && release_tx[g]) |=> o_tx_disable[g])
      else $error("Transmitter re-enabled before status read.");
    chk_all_sent: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_ce |=> alls_ev[g] == $past(i_hdlc_mode[g] && i_tx_last_bit[g] && i_tx_fifo_empty[g]))
      else $error("All-sent flag does not follow last bit, empty FIFO and mode.");
    chk_halt_disabled: assert property (@(posedge i_clk) disable iff (!i_rstn)
      tx_state[g] == TX_HALT |-> o_tx_disable[g])
      else $error("Halted transmitter not held disabled.");
    chk_pool_ready_edge: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_ce && tx_state[g] != TX_HALT && i_tx_space[g] >= TX_BLOCK_BYTES && !space_was_ok[g] |=> xpr_ev[g])
      else $error("Pool ready not raised when space opened.");
    chk_end_cmd_guard: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_ce && xme_pend[g] |=> !o_tx_abort[g])
      else $error("Abort sent although message end was pending.");
  end

  always_comb begin
    ev4 = 8'h00;
    ev4[B_SLIP_POS] = slip_pos_ev;
    ev4[B_SLIP_NEG] = slip_neg_ev;
    ev4[B_RME] = rxi[0].ev_rme;
    ev4[B_RFS] = rxi[0].ev_rfs;
    ev4[B_RDO] = rxi[0].ev_rdo;
    ev4[B_ALLS] = alls_ev[0];
    ev4[B_XDU] = xdu_ev[0];
    ev4[B_RPF] = rxi[0].ev_rpf;
    ev5 = 8'h00;
    ev5[B_POOL_READY_CH2] = xpr_ev[0];
    ev5[B_POOL_READY_CH3] = xpr_ev[1];
    ev5[B_RME] = rxi[1].ev_rme;
    ev5[B_RFS] = rxi[1].ev_rfs;
    ev5[B_RDO] = rxi[1].ev_rdo;
    ev5[B_ALLS] = alls_ev[1];
    ev5[B_XDU] = xdu_ev[1];
    ev5[B_RPF] = rxi[1].ev_rpf;
  end

  // Masked events are kept only when masked status is visible.
  assign rec4 = ev4 & (masked_status_visible ? RST_MASK : ~mask4);
  assign rec5 = ev5 & (masked_status_visible ? RST_MASK : ~mask5);

  always_comb begin
    next_summary = 8'h00;
    next_summary[3:0] = i_other_pending;
    next_summary[4] = pending(status4, mask4);
    next_summary[5] = pending(status5, mask5);
    next_summary[B_PLL] = pll_sync;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pll_meta <= 1'b0;
      pll_sync <= 1'b0;
      slip_pos_ev <= 1'b0;
      slip_neg_ev <= 1'b0;
    end else if (i_ce) begin
      pll_meta <= i_pll_locked;
      pll_sync <= pll_meta;
      slip_pos_ev <= i_tx_slip_pos;
      slip_neg_ev <= i_tx_slip_neg;
    end
  end

  // A new event wins over the clear of the same read.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status4 <= RST_ZERO;
      status5 <= RST_ZERO;
      summary <= RST_ZERO;
      o_int <= 1'b0;
    end else if (i_ce) begin
      status4 <= rec4 | (rd4 ? RST_ZERO : status4);
      status5 <= rec5 | (rd5 ? RST_ZERO : status5);
      summary <= next_summary;
      o_int <= |next_summary[5:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mask4 <= RST_MASK;
      mask5 <= RST_MASK;
      masked_status_visible <= 1'b0;
      addr_low1 <= RST_ZERO;
      o_tx_clock_offset_cfg <= RST_ZERO;
    end else if (wr_take) begin
      if (idx == IDX_MASK4) begin
        mask4 <= i_wb_dat[7:0];
      end else if (idx == IDX_MASK5) begin
        mask5 <= i_wb_dat[7:0];
      end else if (idx == IDX_CONFIG) begin
        masked_status_visible <= i_wb_dat[B_VIS];
      end else if (idx == IDX_ADDR_LOW1) begin
        addr_low1 <= i_wb_dat[7:0];
      end else if (idx == IDX_TX_OFFSET) begin
        o_tx_clock_offset_cfg <= i_wb_dat[7:0];
      end
    end
  end

  always_comb begin
    if (idx == IDX_STATUS4) begin
      rd_val = status4;
    end else if (idx == IDX_STATUS5) begin
      rd_val = status5;
    end else if (idx == IDX_SUMMARY) begin
      rd_val = summary;
    end else if (idx == IDX_MASK4) begin
      rd_val = mask4;
    end else if (idx == IDX_MASK5) begin
      rd_val = mask5;
    end else if (idx == IDX_CONFIG) begin
      rd_val = {7'h00, masked_status_visible};
    end else if (idx == IDX_ADDR_LOW1) begin
      rd_val = addr_low1;
    end else if (idx == IDX_TX_OFFSET) begin
      rd_val = o_tx_clock_offset_cfg;
    end else if (idx == IDX_RX_COUNT2) begin
      rd_val = rxi[0].byte_count;
    end else if (idx == IDX_RX_COUNT3) begin
      rd_val = rxi[1].byte_count;
    end else if (idx == IDX_FRAME_STAT2) begin
      rd_val = rxi[0].frame_status;
    end else if (idx == IDX_FRAME_STAT3) begin
      rd_val = rxi[1].frame_status;
    end else begin
      rd_val = 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else if (i_ce) begin
      o_wb_ack <= req;
      o_wb_dat <= rd_take ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  sequence seq_read4_quiet;
    rd4 && (rec4 & ~mask4) == 8'h00;
  endsequence
  chk_slip_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && i_tx_slip_neg && (masked_status_visible || !mask4[B_SLIP_NEG]) ##1 i_ce |=> status4[B_SLIP_NEG])
    else $error("Negative slip not recorded.");
  chk_clear_on_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
    rd5 |=> status5 == $past(rec5))
    else $error("Status five not cleared by read.");
  chk_summary_track: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce |=> summary[5] == $past(pending(status5, mask5)) && summary[B_PLL] == $past(pll_sync))
    else $error("Summary does not follow status and lock.");
  chk_masked_hidden: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && (status4 & ~mask4) == 8'h00 && (status5 & ~mask5) == 8'h00 && i_other_pending == 4'h0
      |=> !summary[4] && !o_int)
    else $error("Masked event reached summary or interrupt.");
  chk_summary_falls: assert property (@(posedge i_clk) disable iff (!i_rstn)
    seq_read4_quiet ##1 i_ce |=> !summary[4])
    else $error("Summary bit stays after clearing read.");

  chk_read_clears_four: assert property (@(posedge i_clk) disable iff (!i_rstn)
    rd4 |=> status4 == $past(rec4))
    else $error("Status four not cleared by read.");
  chk_pending_raises: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && (status4 & ~mask4) != 8'h00 |=> summary[4] && o_int)
    else $error("Pending status four missing from summary or interrupt.");
  chk_masked_kept: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_ce && masked_status_visible && slip_pos_ev |=> status4[B_SLIP_POS])
    else $error("Masked event not recorded with visibility set.");
  chk_offset_kept: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !wr_take |=> $stable(o_tx_clock_offset_cfg))
    else $error("Transmit clock offset changed without a write.");
endmodule // hdlc_channel_interrupt_status

// ---- tb/hdlc_channel_interrupt_status_tb_top.sv ----
/*
  Self-checking bench for the HDLC channel 2/3 event status block, driven over Wishbone.
  Assumes the design's embedded assertions and a single 100 MHz clock.
*/
`timescale 1ns/100ps
module hdlc_channel_interrupt_status_tb_top;
  import hdlc_irq_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ce = 1'b1;
  logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic [9:0] i_wb_adr = 10'h000;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack, o_int;
  logic i_tx_slip_pos = 1'b0, i_tx_slip_neg = 1'b0, i_pll_locked = 1'b0;
  logic [3:0] i_other_pending = 4'h0;
  logic [1:0] i_rx_byte = 2'h0, i_begin_addr = 2'h0, i_begin_flag = 2'h0, i_transparent = 2'h1;
  logic [1:0] i_rx_fifo_full = 2'h0, i_rx_frame_end = 2'h0, i_addr_low = 2'h3;
  logic [1:0][2:0] i_status_bits = 6'h2d;
  logic [1:0][6:0] i_rx_fifo_level = 14'h0;
  logic [1:0] i_hdlc_mode = 2'h3, i_tx_byte_req = 2'h0, i_tx_fifo_empty = 2'h0, i_tx_last_bit = 2'h0;
  logic [1:0][5:0] i_tx_space = 12'h0;
  logic [1:0] o_tx_disable, o_tx_abort;
  logic [7:0] o_tx_clock_offset_cfg;
  logic [7:0] abort_cnt = 8'h0;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  hdlc_channel_interrupt_status i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_tx_slip_pos(i_tx_slip_pos), .i_tx_slip_neg(i_tx_slip_neg),
    .i_other_pending(i_other_pending), .i_pll_locked(i_pll_locked), .i_rx_byte(i_rx_byte),
    .i_begin_addr(i_begin_addr), .i_begin_flag(i_begin_flag), .i_transparent(i_transparent),
    .i_rx_fifo_full(i_rx_fifo_full), .i_rx_frame_end(i_rx_frame_end), .i_addr_low(i_addr_low),
    .i_status_bits(i_status_bits), .i_rx_fifo_level(i_rx_fifo_level), .i_hdlc_mode(i_hdlc_mode),
    .i_tx_byte_req(i_tx_byte_req), .i_tx_fifo_empty(i_tx_fifo_empty), .i_tx_last_bit(i_tx_last_bit),
    .i_tx_space(i_tx_space), .o_tx_disable(o_tx_disable), .o_tx_abort(o_tx_abort),
    .o_tx_clock_offset_cfg(o_tx_clock_offset_cfg), .o_int(o_int));

  always #5 i_clk = ~i_clk;

  // Counts abort pulses and cuts a hung run short.
  always @(posedge i_clk) begin
    abort_cnt <= i_rstn ? abort_cnt + 8'(o_tx_abort[0]) + 8'(o_tx_abort[1]) : 8'h00;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // One classic cycle; called just after a rising edge.
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= {idx, 2'b00};
    i_wb_sel <= 4'h1;
    i_wb_dat <= {24'h0, wd};
    do begin
      @(posedge i_clk);
    end while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] junk;
    wb(1'b1, idx, wd, junk);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] v;
    wb(1'b0, idx, 8'h00, v);
    chk(v, {24'h0, exp});
  endtask

  initial begin
    logic [31:0] v;
    tick(16);
    i_rstn <= 1'b1;
    tick(2);
    rdc(IDX_SUMMARY, 8'h00);
    rdc(8'h01, 8'h00);
    i_tx_slip_pos <= 1'b1;
    tick(1);
    i_tx_slip_pos <= 1'b0;
    tick(4);
    rdc(IDX_STATUS4, 8'h00);
    wr(IDX_MASK4, 8'h00);
    wr(IDX_MASK5, 8'h00);
    wr(IDX_TX_OFFSET, 8'h5a);
    i_pll_locked <= 1'b1;
    i_other_pending <= 4'ha;
    i_tx_slip_neg <= 1'b1;
    tick(1);
    i_tx_slip_neg <= 1'b0;
    tick(5);
    chk({31'h0, o_int}, 32'h1);
    rdc(IDX_SUMMARY, 8'h5a);
    rdc(IDX_STATUS4, 8'h40);
    rdc(IDX_STATUS4, 8'h00);
    rdc(IDX_SUMMARY, 8'h4a);
    chk({24'h0, o_tx_clock_offset_cfg}, 32'h5a);
    rdc(IDX_TX_OFFSET, 8'h5a);
    i_other_pending <= 4'h0;
    wr(IDX_MASK4, 8'hff);
    wr(IDX_CONFIG, 8'h01);
    i_tx_slip_pos <= 1'b1;
    tick(1);
    i_tx_slip_pos <= 1'b0;
    tick(5);
    chk({31'h0, o_int}, 32'h0);
    rdc(IDX_SUMMARY, 8'h40);
    rdc(IDX_STATUS4, 8'h80);
    wr(IDX_MASK4, 8'h00);
    wr(IDX_CONFIG, 8'h00);
    for (int c = 0; c < 2; c++) begin
      if (c == 0) i_begin_flag[0] <= 1'b1;
      else i_begin_addr[1] <= 1'b1;
      tick(1);
      i_begin_flag <= 2'h0;
      i_begin_addr <= 2'h0;
      repeat (2) begin
        i_rx_byte[c] <= 1'b1;
        tick(1);
        i_rx_byte[c] <= 1'b0;
        tick(1);
      end
      tick(4);
      rdc(IDX_STATUS4 + 8'(c), 8'h10);
      rdc(IDX_FRAME_STAT2 + 8'(c), 8'h0b);
      i_rx_fifo_level[c] <= 7'h20;
      tick(5);
      rdc(IDX_STATUS4 + 8'(c), 8'h01);
      i_rx_fifo_full[c] <= 1'b1;
      i_rx_byte[c] <= 1'b1;
      tick(1);
      i_rx_byte[c] <= 1'b0;
      i_rx_fifo_full[c] <= 1'b0;
      tick(5);
      rdc(IDX_STATUS4 + 8'(c), 8'h08);
      rdc(IDX_FRAME_STAT2 + 8'(c), 8'h2b);
      i_rx_fifo_level[c] <= 7'h05;
      i_rx_frame_end[c] <= 1'b1;
      tick(1);
      i_rx_frame_end[c] <= 1'b0;
      tick(5);
      rdc(IDX_STATUS4 + 8'(c), 8'h20);
      wb(1'b0, IDX_RX_COUNT2 + 8'(c), 8'h00, v);
      chk({25'h0, v[6:0]}, 32'h05);
    end
    for (int c = 0; c < 2; c++) begin
      i_tx_byte_req[c] <= 1'b1;
      tick(1);
      i_tx_byte_req[c] <= 1'b0;
      i_tx_fifo_empty[c] <= 1'b1;
      tick(1);
      i_tx_byte_req[c] <= 1'b1;
      tick(1);
      i_tx_byte_req[c] <= 1'b0;
      tick(4);
      chk({31'h0, o_tx_disable[c]}, 32'h1);
      rdc(IDX_STATUS4 + 8'(c), 8'h02);
      tick(2);
      chk({31'h0, o_tx_disable[c]}, 32'h0);
      i_hdlc_mode[c] <= 1'b0;
      i_tx_last_bit[c] <= 1'b1;
      tick(1);
      i_tx_last_bit[c] <= 1'b0;
      tick(5);
      rdc(IDX_STATUS4 + 8'(c), 8'h00);
      i_hdlc_mode[c] <= 1'b1;
      i_tx_last_bit[c] <= 1'b1;
      tick(1);
      i_tx_last_bit[c] <= 1'b0;
      tick(5);
      rdc(IDX_STATUS4 + 8'(c), 8'h04);
      i_tx_space[c] <= 6'h20;
      tick(5);
      rdc(IDX_STATUS5, (c == 0) ? 8'h80 : 8'h40);
    end
    i_tx_fifo_empty[0] <= 1'b0;
    i_tx_byte_req[0] <= 1'b1;
    tick(1);
    i_tx_byte_req[0] <= 1'b0;
    wr(IDX_TX_CMD, 8'h01);
    i_tx_fifo_empty[0] <= 1'b1;
    i_tx_byte_req[0] <= 1'b1;
    tick(1);
    i_tx_byte_req[0] <= 1'b0;
    tick(4);
    chk({31'h0, o_tx_disable[0]}, 32'h0);
    rdc(IDX_STATUS4, 8'h00);
    wr(IDX_ADDR_LOW1, 8'h3c);
    rdc(IDX_ADDR_LOW1, 8'h3c);
    chk({24'h0, abort_cnt}, 32'h2);
    report_and_stop();
  end
endmodule // hdlc_channel_interrupt_status_tb_top
